/* elfl_pkg.sv */
// package of the enable latch and link fault block: widths, offsets, reset values, mapping defaults
// assumes one 100 MHz clock domain; every field is reached as elfl_pkg::name
package elfl_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int BUS_W = 4;
   localparam int CHAN_N = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int EVT_W = 6;
   localparam int SYNC_W = 14;

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_EVT_STATUS = 8'h00;
   localparam logic [7:0] OFS_EVT_CLEAR = 8'h04;
   localparam logic [7:0] OFS_EVT_ENABLE = 8'h08;
   localparam logic [7:0] OFS_LATCH_STATE = 8'h0C;
   localparam logic [7:0] OFS_LINK_STATE = 8'h10;

   // ****************************************
   // event bit positions
   // ****************************************
   localparam int EVT_FAULT_A = 0;
   localparam int EVT_FAULT_B = 1;
   localparam int EVT_OE_CAPTURE = 2;
   localparam int EVT_RX_CAPTURE = 3;
   localparam int EVT_BIST_CAPTURE = 4;
   localparam int EVT_DEV_RESET = 5;

   // ****************************************
   // latch state register field positions
   // ****************************************
   localparam int LST_OE_LSB = 0;
   localparam int LST_RX_LSB = 4;
   localparam int LST_BIST_LSB = 8;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [3:0] RST_OE_LATCH = 4'h0;
   localparam logic [3:0] RST_RX_LATCH = 4'h0;
   localparam logic [3:0] RST_BIST_LATCH = 4'hF;
   localparam logic [5:0] RST_EVT = 6'h00;
   localparam logic [13:0] RST_SYNC = 14'h0000;

   // ****************************************
   // default bus bit per target, two bits each, target 0 in the low pair
   // ****************************************
   localparam logic [7:0] OE_MAP_DEF = 8'hE4;
   localparam logic [3:0] RX_MAP_DEF = 4'h4;
   localparam logic [7:0] BIST_MAP_DEF = 8'hE4;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic freq_out_of_range;
      logic amplitude_low;
      logic density_low;
   } elfl_fault_t;

   typedef struct packed {
      logic [1:0] rx_bist_en_n;
      logic [1:0] tx_bist_en_n;
      logic [1:0] rx_power_en;
      logic [3:0] driver_en;
   } elfl_cfg_t;

endpackage

/* elfl_top.sv */
// enable latches and link fault outputs of a dual-channel serial transceiver
// assumes pins arrive asynchronously; register port is synchronous to sys_clk
// How it works
// RQ1: while the output-enable latch is open the shared bus steers the serial driver enables.
// RQ2: a high driver-enable bit turns its serial driver on, a low bit powers it down.
// RQ3: when the output-enable latch closes its last bus value is held.
// RQ4: a device reset clears the output-enable latch so every driver is off.
// RQ5: while the receive power latch is open the bus steers the receive power enables, high active, low saving.
// RQ6: when the receive power latch closes its last bus value is held.
// RQ7: a device reset clears the receive power latch so both receive channels are off.
// RQ8: while the self-test latch is open the bus steers the self-test enables, low testing, high normal.
// RQ9: when the self-test latch closes its last bus value is held.
// RQ10: a device reset while the self-test latch is closed returns every channel to normal operation.
// RQ11: each link fault output goes low on frequency out of range or amplitude too low.
// RQ12: it also goes low on low transition density or a disabled receive channel.
// RQ13: each target takes one fixed bus bit, chosen by a parameter.
// RQ14: the controller keeps the bus stable around a closing latch and opens only one latch at a time.
`timescale 1ns/1ps
`default_nettype none

module elfl_top #(
   parameter logic [7:0] OE_MAP = elfl_pkg::OE_MAP_DEF,
   parameter logic [3:0] RX_MAP = elfl_pkg::RX_MAP_DEF,
   parameter logic [7:0] BIST_MAP = elfl_pkg::BIST_MAP_DEF
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // configuration pins
   input wire logic out_enable_latch_open,
   input wire logic rx_power_latch_open,
   input wire logic selftest_latch_open,
   input wire logic [3:0] shared_enable_bus,
   input wire logic device_reset_n,
   // receive fault conditions, one per channel
   input wire elfl_pkg::elfl_fault_t fault_chan_a,
   input wire elfl_pkg::elfl_fault_t fault_chan_b,
   // configuration outputs
   output elfl_pkg::elfl_cfg_t cfg_out,
   // link fault pins
   output logic link_fault_n_chan_a,
   output logic link_fault_n_chan_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // interrupt
   output logic irq
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic pick_bit(input logic [3:0] bus, input logic [1:0] idx);
      pick_bit = bus[idx];
   endfunction

   function automatic logic fell(input logic prev, input logic now);
      fell = prev & ~now;
   endfunction

   // ****************************************
   // pin synchronisers
   // ****************************************
   // three stages; the filtered level moves only when stages two and three agree,
   // so a single-cycle glitch on a pin never reaches the latches
   logic [13:0] pin_raw;
   logic [13:0] sync1_ff;
   logic [13:0] sync2_ff;
   logic [13:0] sync3_ff;
   logic [13:0] filt_ff;
   logic [13:0] filt_prev_ff;

   assign pin_raw = {fault_chan_b, fault_chan_a, device_reset_n, shared_enable_bus,
                     selftest_latch_open, rx_power_latch_open, out_enable_latch_open};

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync1_ff <= elfl_pkg::RST_SYNC;
         sync2_ff <= elfl_pkg::RST_SYNC;
         sync3_ff <= elfl_pkg::RST_SYNC;
      end else begin
         sync1_ff <= pin_raw;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < elfl_pkg::SYNC_W; gi = gi + 1) begin : g_filt
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               filt_ff[gi] <= 1'b0;
            end else if (sync2_ff[gi] == sync3_ff[gi]) begin
               filt_ff[gi] <= sync3_ff[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         filt_prev_ff <= elfl_pkg::RST_SYNC;
      end else begin
         filt_prev_ff <= filt_ff;
      end
   end

   logic oe_open;
   logic rx_open;
   logic bist_open;
   logic [3:0] bus_val;
   logic dev_rst_n;
   elfl_pkg::elfl_fault_t flt_a;
   elfl_pkg::elfl_fault_t flt_b;

   assign oe_open = filt_ff[0];
   assign rx_open = filt_ff[1];
   assign bist_open = filt_ff[2];
   assign bus_val = filt_ff[6:3];
   assign dev_rst_n = filt_ff[7];
   assign flt_a = filt_ff[10:8];
   assign flt_b = filt_ff[13:11];

   logic oe_closed_evt;
   logic rx_closed_evt;
   logic bist_closed_evt;
   logic dev_rst_evt;

   assign oe_closed_evt = fell(filt_prev_ff[0], filt_ff[0]);
   assign rx_closed_evt = fell(filt_prev_ff[1], filt_ff[1]);
   assign bist_closed_evt = fell(filt_prev_ff[2], filt_ff[2]);
   assign dev_rst_evt = fell(filt_prev_ff[7], filt_ff[7]);

   // ****************************************
   // output-enable latch
   // ****************************************
   // the bus is taken each cycle while open, so the value held after closing is the
   // last one seen; the controller keeps the bus steady across the closing edge
   logic [3:0] oe_latch_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         oe_latch_ff <= elfl_pkg::RST_OE_LATCH;
      end else if (!dev_rst_n) begin
         oe_latch_ff <= elfl_pkg::RST_OE_LATCH; // RQ4
      end else if (oe_open) begin
         oe_latch_ff <= bus_val; // RQ1
      end else begin
         oe_latch_ff <= oe_latch_ff; // RQ3
      end
   end

   // ****************************************
   // receive power latch
   // ****************************************
   logic [3:0] rx_latch_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_latch_ff <= elfl_pkg::RST_RX_LATCH;
      end else if (!dev_rst_n) begin
         rx_latch_ff <= elfl_pkg::RST_RX_LATCH; // RQ7
      end else if (rx_open) begin
         rx_latch_ff <= bus_val; // RQ5
      end else begin
         rx_latch_ff <= rx_latch_ff; // RQ6
      end
   end

   // ****************************************
   // self-test latch
   // ****************************************
   // a device reset only clears it while closed: an open latch keeps following the bus
   logic [3:0] bist_latch_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bist_latch_ff <= elfl_pkg::RST_BIST_LATCH;
      end else if (bist_open) begin
         bist_latch_ff <= bus_val; // RQ8
      end else if (!dev_rst_n) begin
         bist_latch_ff <= elfl_pkg::RST_BIST_LATCH; // RQ10
      end else begin
         bist_latch_ff <= bist_latch_ff; // RQ9
      end
   end

   // ****************************************
   // bit-to-target mapping
   // ****************************************
   elfl_pkg::elfl_cfg_t nxt_cfg;

   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_map4
         assign nxt_cfg.driver_en[gi] = pick_bit(oe_latch_ff, OE_MAP[2*gi +: 2]); // RQ2 RQ13
      end
      for (gi = 0; gi < elfl_pkg::CHAN_N; gi = gi + 1) begin : g_map2
         assign nxt_cfg.rx_power_en[gi] = pick_bit(rx_latch_ff, RX_MAP[2*gi +: 2]); // RQ5 RQ13
         assign nxt_cfg.tx_bist_en_n[gi] = pick_bit(bist_latch_ff, BIST_MAP[2*gi +: 2]); // RQ8 RQ13
         assign nxt_cfg.rx_bist_en_n[gi] = pick_bit(bist_latch_ff, BIST_MAP[2*gi+4 +: 2]); // RQ8 RQ13
      end
   endgenerate

   elfl_pkg::elfl_cfg_t cfg_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cfg_ff <= {elfl_pkg::RST_BIST_LATCH, 2'b00, elfl_pkg::RST_OE_LATCH};
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   assign cfg_out = cfg_ff;

   // ****************************************
   // link fault
   // ****************************************
   logic [1:0] nxt_fault;
   logic [1:0] fault_ff;

   assign nxt_fault[0] = flt_a.freq_out_of_range | flt_a.amplitude_low // RQ11
                         | flt_a.density_low | ~cfg_ff.rx_power_en[0]; // RQ12
   assign nxt_fault[1] = flt_b.freq_out_of_range | flt_b.amplitude_low // RQ11
                         | flt_b.density_low | ~cfg_ff.rx_power_en[1]; // RQ12

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fault_ff <= 2'b11;
      end else begin
         fault_ff <= nxt_fault;
      end
   end

   assign link_fault_n_chan_a = ~fault_ff[0];
   assign link_fault_n_chan_b = ~fault_ff[1];

   // ****************************************
   // events
   // ****************************************
   logic [5:0] evt_raw;

   assign evt_raw[elfl_pkg::EVT_FAULT_A] = nxt_fault[0] & ~fault_ff[0];
   assign evt_raw[elfl_pkg::EVT_FAULT_B] = nxt_fault[1] & ~fault_ff[1];
   assign evt_raw[elfl_pkg::EVT_OE_CAPTURE] = oe_closed_evt;
   assign evt_raw[elfl_pkg::EVT_RX_CAPTURE] = rx_closed_evt;
   assign evt_raw[elfl_pkg::EVT_BIST_CAPTURE] = bist_closed_evt;
   assign evt_raw[elfl_pkg::EVT_DEV_RESET] = dev_rst_evt;

   // ****************************************
   // register port
   // ****************************************
   logic wr_clear;
   logic wr_enable;

   assign wr_clear = reg_wr && (reg_addr == elfl_pkg::OFS_EVT_CLEAR);
   assign wr_enable = reg_wr && (reg_addr == elfl_pkg::OFS_EVT_ENABLE);

   logic [5:0] evt_status_ff;
   logic [5:0] evt_enable_ff;

   // a new event beats a clear written in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         evt_status_ff <= elfl_pkg::RST_EVT;
      end else if (wr_clear) begin
         evt_status_ff <= (evt_status_ff & ~reg_wdata[5:0]) | evt_raw;
      end else begin
         evt_status_ff <= evt_status_ff | evt_raw;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         evt_enable_ff <= elfl_pkg::RST_EVT;
      end else if (wr_enable) begin
         evt_enable_ff <= reg_wdata[5:0];
      end
   end

   logic [31:0] nxt_rdata;

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (reg_addr)
         elfl_pkg::OFS_EVT_STATUS: begin
            nxt_rdata[5:0] = evt_status_ff;
         end
         elfl_pkg::OFS_EVT_ENABLE: begin
            nxt_rdata[5:0] = evt_enable_ff;
         end
         elfl_pkg::OFS_LATCH_STATE: begin
            nxt_rdata[elfl_pkg::LST_OE_LSB +: 4] = oe_latch_ff;
            nxt_rdata[elfl_pkg::LST_RX_LSB +: 4] = rx_latch_ff;
            nxt_rdata[elfl_pkg::LST_BIST_LSB +: 4] = bist_latch_ff;
         end
         elfl_pkg::OFS_LINK_STATE: begin
            nxt_rdata[1:0] = fault_ff;
            nxt_rdata[4:2] = {bist_open, rx_open, oe_open};
            nxt_rdata[5] = dev_rst_n;
         end
         default: begin
            nxt_rdata = 32'h0000_0000;
         end
      endcase
   end

   // read data stand only in the cycle after the strobe
   logic [31:0] rdata_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_ff;

   // ****************************************
   // interrupt
   // ****************************************
   logic irq_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(evt_status_ff & evt_enable_ff);
      end
   end

   assign irq = irq_ff;

endmodule

`default_nettype wire

/* elfl_end.sv */
// intentionally minimal: no further logic
`default_nettype none
`default_nettype wire

/* elfl_properties.sv */
// checker of the latch block: pin levels against configuration and fault outputs
// assumes default bus mapping and pins held at least eight cycles
`timescale 1ns/1ps
`default_nettype none
module elfl_properties (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // pins
   input wire logic out_enable_latch_open,
   input wire logic rx_power_latch_open,
   input wire logic selftest_latch_open,
   input wire logic [3:0] shared_enable_bus,
   input wire logic device_reset_n,
   input wire elfl_pkg::elfl_fault_t fault_chan_a,
   input wire elfl_pkg::elfl_fault_t fault_chan_b,
   // outputs
   input wire elfl_pkg::elfl_cfg_t cfg_out,
   input wire logic link_fault_n_chan_a,
   input wire logic link_fault_n_chan_b
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // ****************************************
   // steady open latches
   // ****************************************
   sequence s_oe_open;
      (out_enable_latch_open && device_reset_n && $stable(shared_enable_bus)) [*8];
   endsequence
   sequence s_rx_open;
      (rx_power_latch_open && device_reset_n && $stable(shared_enable_bus)) [*8];
   endsequence
   sequence s_st_open;
      (selftest_latch_open && $stable(shared_enable_bus)) [*8];
   endsequence
   // ****************************************
   // properties
   // ****************************************
   a_oe_follow: assert property (s_oe_open |-> cfg_out.driver_en == shared_enable_bus)
      else $error("driver enables do not follow the bus");
   a_oe_hold: assert property ((!out_enable_latch_open && device_reset_n) [*8] |-> $stable(cfg_out.driver_en))
      else $error("driver enables moved while latch closed");
   a_rx_follow: assert property (s_rx_open |-> cfg_out.rx_power_en == shared_enable_bus[1:0])
      else $error("receive power does not follow the bus");
   a_rx_hold: assert property ((!rx_power_latch_open && device_reset_n) [*8] |-> $stable(cfg_out.rx_power_en))
      else $error("receive power moved while latch closed");
   a_st_follow: assert property (s_st_open |-> {cfg_out.rx_bist_en_n, cfg_out.tx_bist_en_n} == shared_enable_bus)
      else $error("self-test enables do not follow the bus");
   a_st_hold: assert property ((!selftest_latch_open && device_reset_n) [*8] |->
      $stable({cfg_out.rx_bist_en_n, cfg_out.tx_bist_en_n}))
      else $error("self-test enables moved while latch closed");
   a_dev_clear: assert property ((!device_reset_n) [*8] |->
      cfg_out.driver_en == 4'h0 && cfg_out.rx_power_en == 2'h0)
      else $error("device reset left a driver or channel on");
   a_st_clear: assert property ((!device_reset_n && !selftest_latch_open) [*8] |->
      {cfg_out.rx_bist_en_n, cfg_out.tx_bist_en_n} == 4'hF)
      else $error("device reset left self-test on");
   a_fault_fast: assert property ((fault_chan_a.freq_out_of_range || fault_chan_a.amplitude_low) [*8] |->
      !link_fault_n_chan_a)
      else $error("fault a not flagged");
   a_fault_slow: assert property ((fault_chan_b.density_low || !cfg_out.rx_power_en[1]) [*8] |->
      !link_fault_n_chan_b)
      else $error("fault b not flagged");
   a_link_clear: assert property ((fault_chan_a == 3'h0 && cfg_out.rx_power_en[0]) [*8] |->
      link_fault_n_chan_a)
      else $error("fault a flagged without cause");
endmodule

bind elfl_top elfl_properties u_props (
   .sys_clk(sys_clk), .srst(srst), .out_enable_latch_open(out_enable_latch_open),
   .rx_power_latch_open(rx_power_latch_open), .selftest_latch_open(selftest_latch_open),
   .shared_enable_bus(shared_enable_bus), .device_reset_n(device_reset_n),
   .fault_chan_a(fault_chan_a), .fault_chan_b(fault_chan_b), .cfg_out(cfg_out),
   .link_fault_n_chan_a(link_fault_n_chan_a), .link_fault_n_chan_b(link_fault_n_chan_b)
);
`default_nettype wire

/* elfl_ctrl_model.sv */
// controller model: drives latch opens, shared bus and device reset pins
// assumes its tasks are called one at a time from the bench
`timescale 1ns/1ps
`default_nettype none
module elfl_ctrl_model (
   // clock
   input wire logic sys_clk,
   // configuration pins
   output logic out_enable_latch_open,
   output logic rx_power_latch_open,
   output logic selftest_latch_open,
   output logic [3:0] shared_enable_bus,
   output logic device_reset_n
);
   // ****************************************
   // pin sequencing
   // ****************************************
   initial begin
      out_enable_latch_open = 1'b0;
      rx_power_latch_open = 1'b0;
      selftest_latch_open = 1'b0;
      shared_enable_bus = 4'h0;
      device_reset_n = 1'b1;
   end
   // eight quiet cycles after each change: pins are filtered, so less could be missed
   task automatic latch(input int sel, input logic lvl);
      @(posedge sys_clk);
      case (sel)
         0: out_enable_latch_open <= lvl;
         1: rx_power_latch_open <= lvl;
         default: selftest_latch_open <= lvl;
      endcase
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic put_bus(input logic [3:0] v);
      @(posedge sys_clk);
      shared_enable_bus <= v;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic pulse_reset();
      @(posedge sys_clk);
      device_reset_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      device_reset_n <= 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

/* enable_latch_and_link_fault_bench.sv */
// bench of the latch block: controller model on the pins, register port tasks
// assumes default bus mapping of the design
`timescale 1ns/1ps
`default_nettype none
module enable_latch_and_link_fault_bench;
   logic sys_clk = 1'b0;
   logic srst;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   elfl_pkg::elfl_fault_t fault_chan_a;
   elfl_pkg::elfl_fault_t fault_chan_b;
   logic oe_open, rx_open, st_open, dev_rst_n, lf_a, lf_b, irq;
   logic [3:0] bus;
   logic [31:0] rdata;
   elfl_pkg::elfl_cfg_t cfg;
   int bad_count = 0;
   int tests_run = 0;
   always #5 sys_clk = ~sys_clk;
   elfl_ctrl_model ctl (.sys_clk(sys_clk), .out_enable_latch_open(oe_open), .rx_power_latch_open(rx_open),
      .selftest_latch_open(st_open), .shared_enable_bus(bus), .device_reset_n(dev_rst_n));
   elfl_top dut (.sys_clk(sys_clk), .srst(srst), .out_enable_latch_open(oe_open), .rx_power_latch_open(rx_open),
      .selftest_latch_open(st_open), .shared_enable_bus(bus), .device_reset_n(dev_rst_n),
      .fault_chan_a(fault_chan_a), .fault_chan_b(fault_chan_b), .cfg_out(cfg), .link_fault_n_chan_a(lf_a),
      .link_fault_n_chan_b(lf_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(rdata), .irq(irq));
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_cfg(input logic [3:0] oe, input logic [3:0] rx, input logic [3:0] st);
      chk("cfg_out", {22'h0, st, rx[1:0], oe}, {22'h0, cfg});
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", exp, rdata);
   endtask
   task automatic wrap_up();
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ****************************************
   // sequence of tests
   // ****************************************
   initial begin
      srst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      fault_chan_a = 3'h0;
      fault_chan_b = 3'h0;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk_cfg(4'h0, 4'h0, 4'hF);
      chk("link_n", 32'h0, {30'h0, lf_b, lf_a});
      ctl.latch(0, 1'b1);
      ctl.put_bus(4'h5);
      chk_cfg(4'h5, 4'h0, 4'hF);
      ctl.put_bus(4'hA);
      chk_cfg(4'hA, 4'h0, 4'hF);
      ctl.latch(0, 1'b0);
      ctl.put_bus(4'h3);
      chk_cfg(4'hA, 4'h0, 4'hF);
      reg_check(elfl_pkg::OFS_LATCH_STATE, 32'h0000_0F0A);
      ctl.latch(1, 1'b1);
      ctl.put_bus(4'h2);
      chk_cfg(4'hA, 4'h2, 4'hF);
      chk("link_n", 32'h2, {30'h0, lf_b, lf_a});
      ctl.put_bus(4'h3);
      ctl.latch(1, 1'b0);
      ctl.put_bus(4'h6);
      chk_cfg(4'hA, 4'h3, 4'hF);
      reg_check(elfl_pkg::OFS_LINK_STATE, 32'h0000_0020);
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk);
         if (i < 3) fault_chan_a <= 3'(1 << i);
         else fault_chan_b <= 3'(1 << (i - 3));
         repeat (8) @(posedge sys_clk);
         chk("link_n", (i < 3) ? 32'h2 : 32'h1, {30'h0, lf_b, lf_a});
         fault_chan_a <= 3'h0;
         fault_chan_b <= 3'h0;
         repeat (8) @(posedge sys_clk);
         chk("link_n", 32'h3, {30'h0, lf_b, lf_a});
      end
      ctl.latch(2, 1'b1);
      chk_cfg(4'hA, 4'h3, 4'h6);
      ctl.latch(2, 1'b0);
      ctl.put_bus(4'h9);
      chk_cfg(4'hA, 4'h3, 4'h6);
      ctl.pulse_reset();
      chk_cfg(4'h0, 4'h0, 4'hF);
      ctl.put_bus(4'h0);
      ctl.latch(2, 1'b1);
      ctl.pulse_reset();
      chk_cfg(4'h0, 4'h0, 4'h0);
      ctl.latch(2, 1'b0);
      // capture event raises the interrupt, clear drops it, mask hides it
      reg_check(elfl_pkg::OFS_EVT_STATUS, 32'h3F);
      reg_write(elfl_pkg::OFS_EVT_ENABLE, 32'h04);
      reg_write(elfl_pkg::OFS_EVT_CLEAR, 32'h3F);
      reg_check(elfl_pkg::OFS_EVT_ENABLE, 32'h04);
      chk("irq", 32'h0, {31'h0, irq});
      ctl.latch(0, 1'b1);
      ctl.latch(0, 1'b0);
      reg_check(elfl_pkg::OFS_EVT_STATUS, 32'h04);
      chk("irq", 32'h1, {31'h0, irq});
      reg_write(elfl_pkg::OFS_EVT_CLEAR, 32'h04);
      repeat (3) @(posedge sys_clk);
      chk("irq", 32'h0, {31'h0, irq});
      reg_write(elfl_pkg::OFS_EVT_ENABLE, 32'h00);
      ctl.latch(0, 1'b1);
      ctl.latch(0, 1'b0);
      reg_check(elfl_pkg::OFS_EVT_STATUS, 32'h04);
      chk("irq", 32'h0, {31'h0, irq});
      reg_check(8'h14, 32'h0);
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
